// [sadc_pkg.sv]
package sadc_pkg;
  localparam int unsigned CHAN_COUNT = 4;
  localparam int unsigned RESULT_BITS = 8;
  localparam int unsigned CHAN_BITS = 2;
  localparam int unsigned CMD_BITS = 3;
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  // Idle levels: bit 0 select, bit 1 clock, bit 2 command
  localparam logic [2:0] SYNC_RESET = 3'h1;
  localparam logic [2:0] CMD_RESET = 3'h0;
  localparam logic OUT_RESET = 1'h0;
  localparam int unsigned CMD_MODE_POS = 2;
  localparam int unsigned CMD_CHAN_MSB = 1;
  localparam logic CMD_MODE_SINGLE = 1'b0;
  localparam logic CMD_MODE_DIFF = 1'b1;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_CMD,
    SADC_SHIFT,
    SADC_DONE
  } sadc_state_e;
endpackage

// [sadc_sync.sv]
`timescale 1ns/1ps
module sadc_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Asynchronous input and its synchronised copy
  input wire logic async_in,
  input wire logic reset_level,
  output logic sync_out
);
  logic stage1_reg;
  logic stage2_reg;
  logic stage1_next;
  logic stage2_next;

  always_comb begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1_reg <= reset_level;
      stage2_reg <= reset_level;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;
endmodule

// [sadc_serial_adc.sv]
`timescale 1ns/1ps
// Functional notes
// - Conversion runs only while chip select is low; with it high the block idles and floats data.
// - Mode then channel bits enter on the command input, one bit per serial clock transition.
// - After selection eight result bits leave on the result output, one per transition.
// - Four analog channels are selectable and each result is eight bits wide.
module sadc_serial_adc (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host serial lines
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_command_input,
  output logic result_out,
  output logic result_oe_n,
  // Sampled analog values, one byte per channel
  input wire logic [7:0] chan0_value,
  input wire logic [7:0] chan1_value,
  input wire logic [7:0] chan2_value,
  input wire logic [7:0] chan3_value,
  // Status
  output logic conv_busy,
  output logic diff_mode,
  output logic [1:0] sel_chan
);
  logic cs_n_sync;
  logic sclk_sync;
  logic cmd_sync;
  logic sclk_prev_reg;
  logic sclk_prev_next;
  logic edge_seen;
  logic cmd_last;
  logic res_first;
  logic res_last;
  sadc_pkg::sadc_state_e state_reg;
  sadc_pkg::sadc_state_e state_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [2:0] cmd_reg;
  logic [2:0] cmd_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic out_reg;
  logic out_next;
  logic [7:0] chan_value;

  // Synchronisers for host lines
  sadc_sync u_sync_cs (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(chip_select_n),
    .reset_level(sadc_pkg::SYNC_RESET[0]),
    .sync_out(cs_n_sync)
  );
  sadc_sync u_sync_clk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(serial_clock),
    .reset_level(sadc_pkg::SYNC_RESET[1]),
    .sync_out(sclk_sync)
  );
  sadc_sync u_sync_cmd (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(serial_command_input),
    .reset_level(sadc_pkg::SYNC_RESET[2]),
    .sync_out(cmd_sync)
  );

  // Either serial clock edge counts
  always_comb begin
    sclk_prev_next = sclk_sync;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_prev_reg <= sadc_pkg::SYNC_RESET[1];
    end else begin
      sclk_prev_reg <= sclk_prev_next;
    end
  end

  assign edge_seen = (sclk_sync != sclk_prev_reg);

  // Bit position decodes
  assign cmd_last = (count_reg == 4'(sadc_pkg::CMD_BITS - 1));
  assign res_first = (count_reg == sadc_pkg::BIT_COUNT_RESET);
  assign res_last = (count_reg == 4'(sadc_pkg::RESULT_BITS - 1));

  // Channel select of four inputs
  always_comb begin
    case (cmd_reg[sadc_pkg::CMD_CHAN_MSB:0])
      2'h0: chan_value = chan0_value;
      2'h1: chan_value = chan1_value;
      2'h2: chan_value = chan2_value;
      default: chan_value = chan3_value;
    endcase
  end

  // Transaction phase
  always_comb begin
    state_next = state_reg;
    if (cs_n_sync) begin
      state_next = sadc_pkg::SADC_IDLE;
    end else begin
      case (state_reg)
        sadc_pkg::SADC_IDLE: begin
          state_next = sadc_pkg::SADC_CMD;
        end
        sadc_pkg::SADC_CMD: begin
          if (edge_seen && cmd_last) begin
            state_next = sadc_pkg::SADC_SHIFT;
          end
        end
        sadc_pkg::SADC_SHIFT: begin
          if (edge_seen && res_last) begin
            state_next = sadc_pkg::SADC_DONE;
          end
        end
        sadc_pkg::SADC_DONE: begin
          state_next = sadc_pkg::SADC_DONE;
        end
        default: begin
          state_next = sadc_pkg::SADC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= sadc_pkg::SADC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bit counter
  always_comb begin
    count_next = count_reg;
    if (cs_n_sync) begin
      count_next = sadc_pkg::BIT_COUNT_RESET;
    end else begin
      case (state_reg)
        sadc_pkg::SADC_IDLE: begin
          count_next = sadc_pkg::BIT_COUNT_RESET;
        end
        sadc_pkg::SADC_CMD: begin
          if (edge_seen) begin
            count_next = cmd_last ? sadc_pkg::BIT_COUNT_RESET : count_reg + 4'h1;
          end
        end
        sadc_pkg::SADC_SHIFT: begin
          if (edge_seen) begin
            count_next = count_reg + 4'h1;
          end
        end
        default: begin
          count_next = count_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_reg <= sadc_pkg::BIT_COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Command capture, mode first
  always_comb begin
    cmd_next = cmd_reg;
    if (!cs_n_sync && state_reg == sadc_pkg::SADC_CMD && edge_seen) begin
      cmd_next = {cmd_reg[1:0], cmd_sync};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_reg <= sadc_pkg::CMD_RESET;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // Result shifter, MSB first
  always_comb begin
    shift_next = shift_reg;
    out_next = out_reg;
    if (cs_n_sync) begin
      out_next = sadc_pkg::OUT_RESET;
    end else if (state_reg == sadc_pkg::SADC_SHIFT) begin
      if (edge_seen) begin
        if (res_first) begin
          out_next = chan_value[7];
          shift_next = {chan_value[6:0], 1'b0};
        end else begin
          out_next = shift_reg[7];
          shift_next = {shift_reg[6:0], 1'b0};
        end
      end else if (res_first) begin
        shift_next = chan_value;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shift_reg <= sadc_pkg::RESULT_RESET;
      out_reg <= sadc_pkg::OUT_RESET;
    end else begin
      shift_reg <= shift_next;
      out_reg <= out_next;
    end
  end

  // Result line driven from the first result transition through the done phase
  assign result_out = out_reg;
  assign result_oe_n = !((state_reg == sadc_pkg::SADC_SHIFT && !res_first)
    || state_reg == sadc_pkg::SADC_DONE);
  assign conv_busy = (state_reg == sadc_pkg::SADC_CMD) || (state_reg == sadc_pkg::SADC_SHIFT);
  assign diff_mode = cmd_reg[sadc_pkg::CMD_MODE_POS];
  assign sel_chan = cmd_reg[sadc_pkg::CMD_CHAN_MSB:0];
endmodule

// [sadc_assertions.sv]
`timescale 1ns/1ps
module sadc_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Watched ports
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic result_out,
  input wire logic result_oe_n,
  input wire logic conv_busy,
  input wire logic diff_mode,
  input wire logic [1:0] sel_chan
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_idle_when_high: assert property (chip_select_n [*5] |-> result_oe_n && !conv_busy)
    else $error("active while deselected");
  a_busy_needs_select: assert property ($rose(conv_busy) |-> !chip_select_n)
    else $error("busy without select");
  a_result_holds: assert property ((!chip_select_n && $stable(serial_clock)) [*6]
    |-> $stable(result_out)) else $error("result moved without transition");
  a_selection_held: assert property (!result_oe_n && $past(!result_oe_n)
    |-> $stable(sel_chan) && $stable(diff_mode)) else $error("selection moved");
  c_drive: cover property ($fell(result_oe_n));
  c_diff: cover property (diff_mode && !result_oe_n);
  c_chan3: cover property (sel_chan == 2'h3 && !result_oe_n);
endmodule
bind sadc_serial_adc sadc_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .chip_select_n(chip_select_n), .serial_clock(serial_clock), .result_out(result_out),
  .result_oe_n(result_oe_n), .conv_busy(conv_busy), .diff_mode(diff_mode),
  .sel_chan(sel_chan));

// [sadc_host.sv]
`timescale 1ns/1ps
module sadc_host (
  // Clock
  input wire logic clk_sys,
  // Serial lines
  output logic chip_select_n = 1'b1,
  output logic serial_clock = 1'b0,
  output logic serial_command_input = 1'b0,
  input wire logic result_line
);
  task automatic xfer(input logic [2:0] cmd, input int h, output logic [7:0] r);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      if (i < 3) serial_command_input <= cmd[2 - i];
      @(posedge clk_sys);
      serial_clock <= ~serial_clock;
      repeat (h) @(posedge clk_sys);
      if (i > 2) r[10 - i] = result_line;
    end
    chip_select_n <= 1'b1;
    repeat (h) @(posedge clk_sys);
  endtask
  task automatic idle_toggle(input int n, input int h);
    repeat (n) begin
      serial_clock <= ~serial_clock;
      repeat (h) @(posedge clk_sys);
    end
  endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk_sys, sys_rst, cs_n, sclk, cmd_in, res, oe_n, busy, diff;
  logic [1:0] chan;
  logic [7:0] val [4];
  logic [7:0] got;
  int n_mismatch = 0;
  int checks_done = 0;
  wire res_line = oe_n ? ~res : res;
  sadc_serial_adc dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .chip_select_n(cs_n),
    .serial_clock(sclk), .serial_command_input(cmd_in), .result_out(res),
    .result_oe_n(oe_n), .chan0_value(val[0]), .chan1_value(val[1]), .chan2_value(val[2]),
    .chan3_value(val[3]), .conv_busy(busy), .diff_mode(diff), .sel_chan(chan));
  sadc_host host (.clk_sys(clk_sys), .chip_select_n(cs_n), .serial_clock(sclk),
    .serial_command_input(cmd_in), .result_line(res_line));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_channels;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        host.xfer({m[0], c[1:0]}, 5, got);
        chk(got, val[c]);
        chk({7'h00, diff}, {7'h00, m[0]});
        chk({6'h00, chan}, {6'h00, c[1:0]});
        chk({6'h00, busy, oe_n}, 8'h01);
      end
    end
    $display("t_channels done");
  endtask
  task automatic t_deselect;
    host.idle_toggle(6, 5);
    chk({6'h00, busy, oe_n}, 8'h01);
    chk({6'h00, chan}, 8'h03);
    host.xfer(3'h2, 9, got);
    chk(got, val[2]);
    chk({5'h00, diff, chan}, 8'h02);
    $display("t_deselect done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    sys_rst = 1'b1;
    val[0] = 8'hA5;
    val[1] = 8'h3C;
    val[2] = 8'hF0;
    val[3] = 8'h81;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    t_channels;
    t_deselect;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test;
  end
endmodule
